// ==== hw/usbesc_top.v ====
// usb endpoint status and control logic: apb register file, status fifo, endpoint gating, buffer memory
// assumes token and transfer events arrive synchronous to pclk from the serial engine, one per cycle
`timescale 1ns/1ps
`include "usbesc_regs.vh"
module usbesc_top (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [12:0] paddr,
   input wire [31:0] pwdata,
   output reg pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // token from the serial engine
   input wire tok_valid,
   input wire [1:0] tok_pid,
   input wire [6:0] tok_addr,
   input wire [3:0] tok_endp,
   input wire [10:0] tok_frame,
   input wire buf_stall,
   // handshake decision back to the serial engine
   output reg resp_valid,
   output reg [1:0] resp_code,
   // completed transfer report
   input wire xfer_done,
   input wire [3:0] xfer_endp,
   input wire xfer_dir,
   input wire xfer_pingpong_bank_indicator,
   input wire bus_reset,
   // serial engine memory port
   input wire eng_ram_en,
   input wire eng_ram_we,
   input wire [9:0] eng_ram_addr,
   input wire [7:0] eng_ram_wdata,
   output reg [7:0] eng_ram_rdata,
   output reg eng_ram_desc
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function ep_allows;
      input [4:0] ctl;
      input [1:0] pid;
      begin
         case (pid)
            `USBESC_PID_OUT: ep_allows = ctl[`USBESC_EP_OUTEN];
            `USBESC_PID_IN: ep_allows = ctl[`USBESC_EP_INEN];
            `USBESC_PID_SETUP: ep_allows = ctl[`USBESC_EP_OUTEN] & ctl[`USBESC_EP_INEN]
               & ~ctl[`USBESC_EP_CONDIS];
            default: ep_allows = 1'b0;
         endcase
      end
   endfunction

   function in_desc;
      input [9:0] a;
      begin
         in_desc = ({1'b0, a} <= (`USBESC_DESC_LAST - `USBESC_RAM_FIRST));
      end
   endfunction

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire setup_ok = psel & penable & ~pready;
   wire done_acc = psel & penable & pready;
   wire wr_now = done_acc & pwrite;
   wire [10:0] word_idx = paddr[12:2];
   wire hit_ram = (word_idx >= `USBESC_RAM_FIRST) && (word_idx <= `USBESC_RAM_LAST);
   wire hit_ep = (paddr >= `USBESC_EP_BASE) && (paddr <= `USBESC_EP_LAST) && (paddr[1:0] == 2'b00);
   wire [3:0] ep_sel = paddr[5:2];
   wire [9:0] ram_idx = word_idx[9:0];

   reg [6:0] dev_addr;
   reg [10:0] frame_num;
   reg busrst_flag;
   reg done_flag;
   reg [6:0] fifo [0:3];
   reg [1:0] rd_ptr;
   reg [1:0] wr_ptr;
   reg [2:0] fifo_cnt;
   reg [7:0] ram [0:1023];
   wire [4:0] ep_ctl [0:15];
   reg [15:0] stall_set;

   // ----------------------------------------
   // endpoint control registers
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_ep
         reg [4:0] ctl;
         wire wr_ep = wr_now && hit_ep && (ep_sel == gi);
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctl <= `USBESC_EP_RESET;
            end else if (wr_ep) begin
               ctl <= pwdata[4:0];
               if (stall_set[gi]) begin
                  ctl[`USBESC_EP_STALL] <= 1'b1;
               end
            end else if (stall_set[gi]) begin
               ctl[`USBESC_EP_STALL] <= 1'b1;
            end
         end
         assign ep_ctl[gi] = ctl;
      end
   endgenerate

   // ----------------------------------------
   // token handling
   // ----------------------------------------
   wire [4:0] cur_ctl = ep_ctl[tok_endp];
   wire is_sof = tok_pid == `USBESC_PID_SOF;
   wire addr_hit = tok_valid && !is_sof && (tok_addr == dev_addr);
   wire allowed = ep_allows(cur_ctl, tok_pid);
   wire fifo_full = fifo_cnt == `USBESC_FIFO_DEPTH;
   // stall only counts on an enabled endpoint; a disabled one stays silent
   wire do_stall = allowed && (cur_ctl[`USBESC_EP_STALL] | buf_stall);
   reg [1:0] next_code;

   always @* begin
      if (do_stall) begin
         next_code = `USBESC_HS_STALL;
      end else if (fifo_full) begin
         next_code = `USBESC_HS_NAK;
      end else begin
         next_code = `USBESC_HS_ACK;
      end
      if (!cur_ctl[`USBESC_EP_HSHK]) begin
         next_code = `USBESC_HS_NONE;
      end
   end

   always @* begin
      stall_set = 16'h0000;
      stall_set[tok_endp] = addr_hit && do_stall && cur_ctl[`USBESC_EP_HSHK];
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_valid <= 1'b0;
         resp_code <= `USBESC_HS_NONE;
      end else begin
         resp_valid <= addr_hit && allowed;
         resp_code <= (addr_hit && allowed) ? next_code : `USBESC_HS_NONE;
      end
   end

   // ----------------------------------------
   // frame number and device address
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_num <= 11'h000;
      end else if (tok_valid && is_sof) begin
         frame_num <= tok_frame;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_addr <= `USBESC_ADDR_RESET;
         busrst_flag <= 1'b0;
      end else begin
         if (wr_now && paddr == `USBESC_ADDR_OFS) begin
            dev_addr <= pwdata[6:0];
         end
         if (wr_now && paddr == `USBESC_FLAGS_OFS && pwdata[`USBESC_FL_BUSRST]) begin
            busrst_flag <= 1'b0;
         end
         // bus reset wins over a same-cycle write or clear
         if (bus_reset) begin
            dev_addr <= `USBESC_ADDR_RESET;
            busrst_flag <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // status fifo
   // ----------------------------------------
   wire pop = wr_now && paddr == `USBESC_FLAGS_OFS && pwdata[`USBESC_FL_DONE] && fifo_cnt != 3'h0;
   wire push = xfer_done && (!fifo_full || pop);
   reg [2:0] next_cnt;

   always @* begin
      next_cnt = fifo_cnt;
      if (push && !pop) begin
         next_cnt = fifo_cnt + 3'h1;
      end else if (pop && !push) begin
         next_cnt = fifo_cnt - 3'h1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ptr <= 2'h0;
         wr_ptr <= 2'h0;
         fifo_cnt <= 3'h0;
         done_flag <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 2'h1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 2'h1;
         end
         fifo_cnt <= next_cnt;
         // a waiting entry raises the flag again at once; a push beats the clear
         done_flag <= next_cnt != 3'h0;
      end
   end

   // entries need no reset: the count says which ones are valid
   always @(posedge pclk) begin
      if (push) begin
         fifo[wr_ptr] <= {xfer_endp, xfer_dir, xfer_pingpong_bank_indicator, 1'b0};
      end
   end

   // ----------------------------------------
   // dual-port buffer memory
   // ----------------------------------------
   always @(posedge pclk) begin
      if (wr_now && hit_ram) begin
         ram[ram_idx] <= pwdata[7:0];
      end
      // no arbitration here: ownership is kept by firmware and descriptors
      if (eng_ram_en && eng_ram_we) begin
         ram[eng_ram_addr] <= eng_ram_wdata;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eng_ram_rdata <= 8'h00;
         eng_ram_desc <= 1'b0;
      end else begin
         if (eng_ram_en) begin
            eng_ram_rdata <= ram[eng_ram_addr];
         end
         eng_ram_desc <= eng_ram_en && in_desc(eng_ram_addr);
      end
   end

   // ----------------------------------------
   // apb read mux and answer
   // ----------------------------------------
   reg [31:0] next_rdata;
   reg next_err;

   always @* begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (hit_ram) begin
         next_rdata[7:0] = ram[ram_idx];
      end else if (hit_ep) begin
         next_rdata[4:0] = ep_ctl[ep_sel];
      end else begin
         case (paddr)
            `USBESC_STATUS_OFS: begin
               // an empty fifo reads zero, never a stale or unknown entry
               if (fifo_cnt != 3'h0) begin
                  next_rdata[6:0] = fifo[rd_ptr];
               end
            end
            `USBESC_FLAGS_OFS: begin
               next_rdata[`USBESC_FL_DONE] = done_flag;
               next_rdata[`USBESC_FL_BUSRST] = busrst_flag;
               next_rdata[`USBESC_FL_FULL] = fifo_full;
            end
            `USBESC_ADDR_OFS: next_rdata[6:0] = dev_addr;
            `USBESC_FRML_OFS: next_rdata[7:0] = frame_num[7:0];
            `USBESC_FRMH_OFS: next_rdata[2:0] = frame_num[10:8];
            default: next_err = 1'b1;
         endcase
      end
      // frame and status registers ignore writes; a write there is flagged
      if (pwrite && (paddr == `USBESC_STATUS_OFS || paddr == `USBESC_FRML_OFS
            || paddr == `USBESC_FRMH_OFS)) begin
         next_err = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ok;
         pslverr <= setup_ok && next_err;
         prdata <= (setup_ok && !pwrite) ? next_rdata : 32'h0000_0000;
      end
   end

endmodule

// ==== hw/usbesc_regs.vh ====
// register offsets, field positions, reset values and codes for the usb endpoint status block
// assumes byte addressing on a 32-bit apb bus, one word per register
`ifndef USBESC_REGS_VH
`define USBESC_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define USBESC_STATUS_OFS 13'h0000
`define USBESC_FLAGS_OFS 13'h0004
`define USBESC_ADDR_OFS 13'h0008
`define USBESC_FRML_OFS 13'h000C
`define USBESC_FRMH_OFS 13'h0010
`define USBESC_EP_BASE 13'h0040
`define USBESC_EP_LAST 13'h007C
// buffer memory word index 400h..7ffh, byte address is four times the index
`define USBESC_RAM_FIRST 11'h0400
`define USBESC_RAM_LAST 11'h07FF
`define USBESC_DESC_LAST 11'h04FF
// ----------------------------------------
// field positions
// ----------------------------------------
`define USBESC_ST_ENDP_HI 6
`define USBESC_ST_ENDP_LO 3
`define USBESC_ST_DIR 2
`define USBESC_ST_PINGPONG_BANK_INDICATOR 1
`define USBESC_EP_HSHK 4
`define USBESC_EP_CONDIS 3
`define USBESC_EP_OUTEN 2
`define USBESC_EP_INEN 1
`define USBESC_EP_STALL 0
`define USBESC_FL_DONE 0
`define USBESC_FL_BUSRST 1
`define USBESC_FL_FULL 2
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define USBESC_EP_RESET 5'h00
`define USBESC_ADDR_RESET 7'h00
`define USBESC_FIFO_DEPTH 3'h4
// ----------------------------------------
// token and handshake codes
// ----------------------------------------
`define USBESC_PID_OUT 2'h0
`define USBESC_PID_IN 2'h1
`define USBESC_PID_SETUP 2'h2
`define USBESC_PID_SOF 2'h3
`define USBESC_HS_ACK 2'h0
`define USBESC_HS_NAK 2'h1
`define USBESC_HS_STALL 2'h2
`define USBESC_HS_NONE 2'h3
`endif

// ==== bench/usbesc_assertions.sv ====
// checker for the usb endpoint status block, port level only
// assumes one domain: pclk with presetn as asynchronous reset
`timescale 1ns/1ps
`include "usbesc_regs.vh"
module usbesc_assertions (
   // apb
   input wire pclk,
   input wire presetn,
   input wire pwrite,
   input wire [12:0] paddr,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   // tokens and engine memory
   input wire tok_valid,
   input wire [1:0] tok_pid,
   input wire resp_valid,
   input wire eng_ram_en,
   input wire [9:0] eng_ram_addr,
   input wire eng_ram_desc
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_status_read_only:
      assert property (pready && pwrite && paddr == `USBESC_STATUS_OFS |-> pslverr) else $error("status write taken");
   a_status_spare_bits:
      assert property (pready && !pwrite && paddr == `USBESC_STATUS_OFS |-> prdata[31:7] == 0 && !prdata[0])
      else $error("status spare bits set");
   a_endpoint_spare_bits:
      assert property (pready && !pwrite && paddr >= `USBESC_EP_BASE && paddr <= `USBESC_EP_LAST
      |-> prdata[31:5] == 0) else $error("endpoint spare bits set");
   a_frame_read_only:
      assert property (pready && pwrite && (paddr == `USBESC_FRML_OFS || paddr == `USBESC_FRMH_OFS) |-> pslverr)
      else $error("frame write taken");
   a_sof_silent:
      assert property (tok_valid && tok_pid == `USBESC_PID_SOF |=> !resp_valid) else $error("answer to sof");
   a_answer_has_token:
      assert property (resp_valid |-> $past(tok_valid) && $past(tok_pid) != `USBESC_PID_SOF)
      else $error("answer without token");
   a_desc_area_flag:
      assert property (eng_ram_en && eng_ram_addr <= 10'h0FF |-> ##1 eng_ram_desc) else $error("desc flag low");
   a_data_area_flag:
      assert property (eng_ram_en && eng_ram_addr > 10'h0FF |=> !eng_ram_desc) else $error("desc flag high");
endmodule
bind usbesc_top usbesc_assertions chk (.*);

// ==== bench/usbesc_host.sv ====
// host-side model: tokens, transfer reports, bus reset, engine memory cycles
// assumes tasks are called from one bench process, one at a time
`timescale 1ns/1ps
module usbesc_host (
   // clock and answers
   input wire pclk,
   input wire resp_valid,
   input wire [1:0] resp_code,
   input wire [7:0] eng_ram_rdata,
   input wire eng_ram_desc,
   // tokens and reports
   output reg tok_valid = '0, buf_stall = '0, xfer_done = '0, xfer_dir = '0, xfer_pingpong_bank_indicator = '0, bus_reset = '0,
   output reg [1:0] tok_pid = '0,
   output reg [6:0] tok_addr = '0,
   output reg [3:0] tok_endp = '0, xfer_endp = '0,
   output reg [10:0] tok_frame = '0,
   // engine memory port
   output reg eng_ram_en = '0, eng_ram_we = '0,
   output reg [9:0] eng_ram_addr = '0,
   output reg [7:0] eng_ram_wdata = '0
);
   // released pid, address and endpoint lines carry the inverse; tok_frame keeps its last value
   task tok(input [1:0] pid, input [6:0] a, input [3:0] ep, input st, output v, output [1:0] c);
      begin
         @(posedge pclk);
         tok_valid <= 1'b1;
         tok_pid <= pid;
         tok_addr <= a;
         tok_endp <= ep;
         tok_frame <= 11'h5A3;
         buf_stall <= st;
         @(posedge pclk);
         tok_valid <= 1'b0;
         tok_pid <= ~pid;
         tok_addr <= ~a;
         tok_endp <= ~ep;
         buf_stall <= 1'b0;
         #1;
         v = resp_valid;
         c = resp_code;
      end
   endtask
   task rep(input rst, input [3:0] ep, input d, input pp);
      begin
         @(posedge pclk);
         bus_reset <= rst;
         xfer_done <= !rst;
         xfer_endp <= ep;
         xfer_dir <= d;
         xfer_pingpong_bank_indicator <= pp;
         @(posedge pclk);
         bus_reset <= 1'b0;
         xfer_done <= 1'b0;
         xfer_endp <= ~ep;
      end
   endtask
   task ram(input we, input [9:0] a, input [7:0] d, output [8:0] q);
      begin
         @(posedge pclk);
         eng_ram_en <= 1'b1;
         eng_ram_we <= we;
         eng_ram_addr <= a;
         eng_ram_wdata <= d;
         @(posedge pclk);
         eng_ram_en <= 1'b0;
         eng_ram_addr <= ~a;
         #1;
         q = {eng_ram_desc, eng_ram_rdata};
      end
   endtask
endmodule

// ==== bench/usbesc_bench.sv ====
// self-checking bench: apb master in here, host model on the engine side
// assumes the register header is on the include path
`timescale 1ns/1ps
`include "usbesc_regs.vh"
module usbesc_bench;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [12:0] paddr = '0;
   reg [31:0] pwdata = '0, r;
   wire pready, pslverr, resp_valid, tok_valid, buf_stall, xfer_done, xfer_dir, xfer_pingpong_bank_indicator, bus_reset;
   wire eng_ram_en, eng_ram_we, eng_ram_desc;
   wire [31:0] prdata;
   wire [1:0] resp_code, tok_pid;
   wire [6:0] tok_addr;
   wire [3:0] tok_endp, xfer_endp;
   wire [10:0] tok_frame;
   wire [9:0] eng_ram_addr;
   wire [7:0] eng_ram_wdata, eng_ram_rdata;
   integer fails = 0, comparisons = 0, i;
   reg e, v;
   reg [1:0] c;
   reg [8:0] q;
   always #2.5 pclk = ~pclk;
   usbesc_top dut (.*);
   usbesc_host host (.*);
   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // request held until pready is sampled high
   task apb(input w, input [12:0] a, input [31:0] d, input xe);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         // no local limit: only the watchdog ends a wait
         while (pready !== 1'b1) begin
            @(posedge pclk);
         end
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         chk(e, xe);
      end
   endtask
   task rd(input [12:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, '0, 1'b0);
         chk(r, exp);
      end
   endtask
   task tk(input [1:0] p, input [6:0] a, input [3:0] n, input st, input [2:0] exp);
      begin
         host.tok(p, a, n, st, v, c);
         chk({v, c}, exp);
      end
   endtask
   function [12:0] ep(input integer n);
      ep = 13'(`USBESC_EP_BASE + 4 * n);
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
      for (i = 0; i < 16; i = i + 1) begin
         rd(ep(i), 0);
         apb(1'b1, ep(i), (i == 0) ? 32'h0000_00F7 : 32'hFFFF_FFFF, 1'b0);
         rd(ep(i), (i == 0) ? 32'h0000_0017 : 32'h0000_001F);
         apb(1'b1, ep(i), 0, 1'b0);
      end
      rd(`USBESC_ADDR_OFS, 0);
      apb(1'b0, 13'h0080, 0, 1'b1);
   endtask
   task t_tok;
      apb(1'b1, `USBESC_ADDR_OFS, 32'h0000_002A, 1'b0);
      apb(1'b1, ep(1), 32'h0000_0016, 1'b0);
      tk(`USBESC_PID_IN, 7'h2A, 1, 0, 3'h4);
      tk(`USBESC_PID_OUT, 7'h2A, 1, 0, 3'h4);
      tk(`USBESC_PID_SETUP, 7'h2A, 1, 0, 3'h4);
      tk(`USBESC_PID_IN, 7'h2B, 1, 0, 3'h3);
      tk(`USBESC_PID_IN, 7'h2A, 2, 0, 3'h3);
      apb(1'b1, ep(1), 32'h0000_000E, 1'b0);
      tk(`USBESC_PID_IN, 7'h2A, 1, 0, 3'h7);
      tk(`USBESC_PID_SETUP, 7'h2A, 1, 0, 3'h3);
      apb(1'b1, ep(1), 32'h0000_0016, 1'b0);
      tk(`USBESC_PID_IN, 7'h2A, 1, 1, 3'h6);
      rd(ep(1), 32'h0000_0017);
      tk(`USBESC_PID_OUT, 7'h2A, 1, 0, 3'h6);
      apb(1'b1, ep(1), 32'h0000_0016, 1'b0);
      rd(ep(1), 32'h0000_0016);
      apb(1'b1, ep(2), 32'h0000_0012, 1'b0);
      tk(`USBESC_PID_OUT, 7'h2A, 2, 0, 3'h3);
      tk(`USBESC_PID_IN, 7'h2A, 2, 0, 3'h4);
      apb(1'b1, ep(3), 32'h0000_0011, 1'b0);
      tk(`USBESC_PID_IN, 7'h2A, 3, 1, 3'h3);
      rd(ep(3), 32'h0000_0011);
   endtask
   // fifth report arrives while full and must be dropped
   task t_fifo;
      for (i = 0; i < 5; i = i + 1) host.rep(1'b0, 4'(9 + i), i[0], i[1]);
      rd(`USBESC_FLAGS_OFS, 32'h0000_0005);
      tk(`USBESC_PID_IN, 7'h2A, 2, 0, 3'h5);
      for (i = 0; i < 4; i = i + 1) begin
         rd(`USBESC_STATUS_OFS, ((9 + i) << 3) | (i[0] << 2) | (i[1] << 1));
         apb(1'b1, `USBESC_FLAGS_OFS, 32'h0000_0001, 1'b0);
         rd(`USBESC_FLAGS_OFS, (i < 3) ? 1 : 0);
      end
      rd(`USBESC_FLAGS_OFS, 0);
   endtask
   task t_bus;
      host.rep(1'b1, 0, 0, 0);
      rd(`USBESC_ADDR_OFS, 0);
      rd(`USBESC_FLAGS_OFS, 32'h0000_0002);
      apb(1'b1, `USBESC_FLAGS_OFS, 32'h0000_0002, 1'b0);
      rd(`USBESC_FLAGS_OFS, 0);
      tk(`USBESC_PID_IN, 7'h2A, 2, 0, 3'h3);
      tk(`USBESC_PID_IN, 7'h00, 2, 0, 3'h4);
      tk(`USBESC_PID_SOF, 7'h00, 0, 0, 3'h3);
      rd(`USBESC_FRML_OFS, 32'h0000_00A3);
      rd(`USBESC_FRMH_OFS, 32'h0000_0005);
      apb(1'b1, `USBESC_FRML_OFS, 0, 1'b1);
      rd(`USBESC_FRML_OFS, 32'h0000_00A3);
   endtask
   // engine reads a byte firmware wrote, firmware reads a byte the engine wrote
   task t_ram;
      apb(1'b1, 13'h1000, 32'h0000_005C, 1'b0);
      host.ram(1'b0, 10'h000, 0, q);
      chk(q, 9'h15C);
      apb(1'b1, 13'h1FFC, 32'h0000_00A7, 1'b0);
      host.ram(1'b0, 10'h3FF, 0, q);
      chk(q, 9'h0A7);
      host.ram(1'b1, 10'h100, 8'h3E, q);
      chk(q[8], 1'b0);
      rd(13'h1400, 32'h0000_003E);
   endtask
   // ----------------------------------------
   // sequence, watchdog, verdict
   // ----------------------------------------
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, fails);
         if (fails == 0 && comparisons > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_tok;
      t_fifo;
      t_bus;
      t_ram;
      close_out;
   end
   initial begin
      #100000;
      fails = fails + 1;
      close_out;
   end
endmodule
